// >>> common/rss_pkg.sv
package rss_pkg;
  // register byte offsets
  localparam logic [7:0] RSS_OFF_CTRL  = 8'h00;
  localparam logic [7:0] RSS_OFF_COUNT = 8'h04;
  localparam logic [7:0] RSS_OFF_DELAY = 8'h08;
  localparam logic [7:0] RSS_OFF_SRC   = 8'h0C;
  localparam logic [7:0] RSS_OFF_LEN   = 8'h10;
  localparam logic [7:0] RSS_OFF_STAT  = 8'h14;
  localparam logic [7:0] RSS_OFF_POS   = 8'h18;
  // control register bits (write-one pulses)
  localparam int RSS_CTRL_INIT  = 0;
  localparam int RSS_CTRL_ABORT = 1;
  localparam int RSS_CTRL_IMM   = 2;
  // source register fields
  localparam int RSS_SRC_MODE_LSB = 0;
  localparam int RSS_SRC_LINE_LSB = 4;
  // status register bits
  localparam int RSS_STAT_BUSY    = 0;
  localparam int RSS_STAT_CNT_ERR = 1;
  localparam int RSS_STAT_DLY_ERR = 2;
  localparam int RSS_STAT_SRC_ERR = 3;
  // position register field
  localparam int RSS_POS_PASS_LSB = 16;
  // reset values
  localparam logic [15:0] RSS_COUNT_RST = 16'h0001;
  localparam logic [15:0] RSS_DELAY_RST = 16'h0000;
  // timing: delay unit and module clock
  localparam int RSS_DELAY_UNIT_US = 100;
  localparam int RSS_CLK_MHZ       = 200;
  localparam int RSS_TICK_CYC      = RSS_DELAY_UNIT_US * RSS_CLK_MHZ;
  // trigger source modes
  typedef enum logic [1:0] {
    RSS_SRC_IMM  = 2'h0,
    RSS_SRC_TTL  = 2'h1,
    RSS_SRC_HOLD = 2'h2
  } rss_src_t;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    RSS_ST_IDLE  = 5'h01,
    RSS_ST_ARMED = 5'h02,
    RSS_ST_DELAY = 5'h04,
    RSS_ST_OPEN  = 5'h08,
    RSS_ST_CLOSE = 5'h10
  } rss_state_t;
endpackage : rss_pkg

// >>> common/rss_cfg_if.sv
interface rss_cfg_if #(parameter int IW = 6);
  import rss_pkg::*;
  logic [15:0]   count;     // passes per scan
  logic [15:0]   delay;     // post-trigger delay, 100 us units
  rss_src_t      src_mode;  // trigger source
  logic [2:0]    src_line;  // selected backplane line
  logic [IW:0]   list_len;  // relays in the scan list
  logic          init_p;    // start pulse
  logic          abort_p;   // abort pulse
  logic          imm_p;     // immediate step pulse
  logic          busy;      // scan in progress
  logic [IW-1:0] idx;       // current list position
  logic [15:0]   pass;      // current pass number
  modport regs (output count, delay, src_mode, src_line, list_len, init_p, abort_p, imm_p,
                input busy, idx, pass);
  modport seq  (input count, delay, src_mode, src_line, list_len, init_p, abort_p, imm_p,
                output busy, idx, pass);
endinterface : rss_cfg_if

// >>> verilog/rss_tick.sv
module rss_tick #(
  parameter int CYC = 20000
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // restart phase, tick out
  input  wire logic clr,
  output logic      tick
);
  localparam int CW = $clog2(CYC);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] cnt_ff;  // cycles into the current unit
  logic          at_last;
  assign at_last = (cnt_ff == LAST);
  assign tick    = at_last & ~clr;
  // free count, restarted so a delay starts on a whole unit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cnt_ff <= '0;
    else if (clr || at_last) cnt_ff <= '0;
    else cnt_ff <= cnt_ff + 1'b1;
  end
endmodule : rss_tick

// >>> verilog/rss_wb_regs.sv
module rss_wb_regs #(
  parameter int N  = 64,
  parameter int IW = 6
) (
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  rst,
  // wishbone slave
  input  wire logic  wb_cyc_i,
  input  wire logic  wb_stb_i,
  input  wire logic  wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  // sequencer side
  rss_cfg_if.regs     cfg
);
  import rss_pkg::*;
  logic        ack_ff, nxt_ack;
  logic [31:0] dat_ff;
  logic [15:0] count_ff, delay_ff;
  logic [1:0]  mode_ff;
  logic [2:0]  line_ff;
  logic [IW:0] len_ff;
  logic [2:0]  ctrl_ff;              // pulses: imm, abort, init
  logic [2:0]  err_ff;               // sticky: src, delay, count
  logic        acc, wr;
  logic [31:0] wval, rdata;
  logic        cnt_ok, dly_ok, src_ok, len_ok;
  logic        wr_ctrl, wr_cnt, wr_dly, wr_src, wr_len, wr_stat;
  logic [2:0]  err_set, err_clr;

  // byte lanes merged into a base value; writes merge over zero
  function automatic logic [31:0] rss_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : rss_merge

  // one access per request; ack falls the cycle after it rose
  assign acc     = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr      = acc & wb_we_i;
  assign nxt_ack = acc;
  assign wr_ctrl = wr & (wb_adr_i == RSS_OFF_CTRL);
  assign wr_cnt  = wr & (wb_adr_i == RSS_OFF_COUNT);
  assign wr_dly  = wr & (wb_adr_i == RSS_OFF_DELAY);
  assign wr_src  = wr & (wb_adr_i == RSS_OFF_SRC);
  assign wr_len  = wr & (wb_adr_i == RSS_OFF_LEN);
  assign wr_stat = wr & (wb_adr_i == RSS_OFF_STAT);
  assign wval    = rss_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign cnt_ok  = (wval[31:16] == 16'h0000) && (wval[15:0] != 16'h0000);
  assign dly_ok  = (wval[31:16] == 16'h0000);
  assign src_ok  = (wval[1:0] != 2'h3);
  assign len_ok  = (wval != 32'h0000_0000) && (wval <= 32'(N));
  assign err_set = {wr_src & ~src_ok, wr_dly & ~dly_ok, wr_cnt & ~cnt_ok};
  assign err_clr = wr_stat ? wval[RSS_STAT_SRC_ERR:RSS_STAT_CNT_ERR] : 3'h0;

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      RSS_OFF_COUNT: rdata = {16'h0000, count_ff};
      RSS_OFF_DELAY: rdata = {16'h0000, delay_ff};
      RSS_OFF_SRC:   rdata = 32'({line_ff, 2'h0, mode_ff});
      RSS_OFF_LEN:   rdata = 32'(len_ff);
      RSS_OFF_STAT:  rdata = {28'h0000000, err_ff, cfg.busy};
      RSS_OFF_POS:   rdata = {cfg.pass, 16'(cfg.idx)};
      default:       rdata = 32'h0000_0000;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      if (acc) dat_ff <= rdata;
    end
  end

  // settings; a bad value is refused and the old one kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_ff <= RSS_COUNT_RST;
      delay_ff <= RSS_DELAY_RST;
      mode_ff  <= RSS_SRC_IMM;
      line_ff  <= 3'h0;
      len_ff   <= (IW+1)'(N);
    end else begin
      if (wr_cnt && cnt_ok) count_ff <= wval[15:0];
      if (wr_dly && dly_ok) delay_ff <= wval[15:0];
      if (wr_src && src_ok) begin
        mode_ff <= wval[RSS_SRC_MODE_LSB +: 2];
        line_ff <= wval[RSS_SRC_LINE_LSB +: 3];
      end
      if (wr_len && len_ok) len_ff <= wval[IW:0];
    end
  end

  // command pulses and sticky errors; a new error beats its clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 3'h0;
      err_ff  <= 3'h0;
    end else begin
      ctrl_ff <= wr_ctrl ? wval[2:0] : 3'h0;
      err_ff  <= (err_ff & ~err_clr) | err_set;
    end
  end

  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = dat_ff;
  assign cfg.count    = count_ff;
  assign cfg.delay    = delay_ff;
  assign cfg.src_mode = rss_src_t'(mode_ff);
  assign cfg.src_line = line_ff;
  assign cfg.list_len = len_ff;
  assign cfg.init_p   = ctrl_ff[RSS_CTRL_INIT];
  assign cfg.abort_p  = ctrl_ff[RSS_CTRL_ABORT];
  assign cfg.imm_p    = ctrl_ff[RSS_CTRL_IMM];
endmodule : rss_wb_regs

// >>> verilog/rss_top.sv
// Function
// - repeat count only 1 to 65535
// - walk whole list exactly count times
// - back to idle after last pass
// - delay only 0 to 6.5535 seconds
// - wait delay after trigger before opening
// - open current relay, then close next
// - immediate source steps without trigger
// - selected backplane line steps the scan
// - delay after each line assertion, repeat
// - immediate command steps now, no delay
module rss_top
  import rss_pkg::*;
#(
  parameter int N           = 64,
  parameter int TICK_CYCLES = rss_pkg::RSS_TICK_CYC
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // backplane trigger lines, active high
  input  wire logic [7:0]    trig_line_i,
  // relay drive and scan state
  output logic [N-1:0]       relay_close_o,
  output logic               scan_busy_o
);
  import rss_pkg::*;
  localparam int IW = $clog2(N);

  rss_cfg_if #(.IW(IW)) cfg ();   // settings and status between regs and sequencer

  rss_state_t    st_ff, nxt_st;     // sequencer state
  logic [IW-1:0] idx_ff, nxt_idx;   // list position
  logic [15:0]   pass_ff, nxt_pass; // passes finished in this scan
  logic [15:0]   dly_ff, nxt_dly;   // delay units left
  logic [N-1:0]  relay_ff, nxt_relay;
  logic          busy_ff;
  logic [7:0]    s1_ff, s2_ff, s3_ff; // line synchronisers
  logic [7:0]    filt_ff, prev_ff;  // settled line levels
  logic [7:0]    line_rise;
  logic          trig_evt;          // event on the selected line
  logic          fire;              // source says step now
  logic          tick;              // one delay unit elapsed
  logic          tick_clr;
  logic          at_end, last_pass, dly_done;

  // register file on the bus
  rss_wb_regs #(.N(N), .IW(IW)) u_regs (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg      (cfg)
  );

  // 100 us enable for the delay count
  rss_tick #(.CYC(TICK_CYCLES)) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (tick_clr),
    .tick    (tick)
  );

  // a line level counts once the second and third stages agree,
  // which rejects a single-cycle glitch at the cost of latency
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_ff   <= 8'h00;
      s2_ff   <= 8'h00;
      s3_ff   <= 8'h00;
      filt_ff <= 8'h00;
      prev_ff <= 8'h00;
    end else begin
      s1_ff   <= trig_line_i;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
      prev_ff <= filt_ff;
    end
  end

  assign line_rise = filt_ff & ~prev_ff;
  assign trig_evt  = line_rise[cfg.src_line];
  assign fire      = (cfg.src_mode == RSS_SRC_IMM) |
                     ((cfg.src_mode == RSS_SRC_TTL) & trig_evt);
  // length is read live; cutting it below the current position mid-scan
  // lets the index run on until it wraps, so change it only while idle
  assign at_end    = ({1'b0, idx_ff} == (cfg.list_len - 1'b1));
  assign last_pass = (pass_ff == (cfg.count - 16'h0001));
  assign dly_done  = tick & (dly_ff == 16'h0001);
  // restart the unit timer so a delay is never cut short
  assign tick_clr  = st_ff == RSS_ST_ARMED;

  // next state and datapath of the sequencer
  always_comb begin
    nxt_st    = st_ff;
    nxt_idx   = idx_ff;
    nxt_pass  = pass_ff;
    nxt_dly   = dly_ff;
    nxt_relay = relay_ff;
    unique case (st_ff)
      RSS_ST_IDLE: begin
        // start by closing the first relay of the list
        if (cfg.init_p) begin
          nxt_idx  = '0;
          nxt_pass = 16'h0000;
          nxt_st   = RSS_ST_CLOSE;
        end
      end
      RSS_ST_ARMED: begin
        // line events outside this state are dropped, not queued
        // immediate command skips wait and delay
        if (cfg.imm_p) begin
          nxt_st = RSS_ST_OPEN;
        end else if (fire) begin
          nxt_dly = cfg.delay;
          nxt_st  = (cfg.delay == 16'h0000) ? RSS_ST_OPEN : RSS_ST_DELAY;
        end
      end
      RSS_ST_DELAY: begin
        // count delay units after each trigger
        if (cfg.imm_p || dly_done) begin
          nxt_st = RSS_ST_OPEN;
        end else if (tick) begin
          nxt_dly = dly_ff - 16'h0001;
        end
      end
      RSS_ST_OPEN: begin
        nxt_relay = '0;
        if (!at_end) begin
          nxt_idx = IW'(idx_ff + 1'b1);
          nxt_st  = RSS_ST_CLOSE;
        end else if (last_pass) begin
          nxt_st = RSS_ST_IDLE;
        end else begin
          nxt_idx  = '0;
          nxt_pass = pass_ff + 16'h0001;
          nxt_st   = RSS_ST_CLOSE;
        end
      end
      RSS_ST_CLOSE: begin
        nxt_relay = N'(1) << idx_ff;
        nxt_st    = RSS_ST_ARMED;
      end
      default: begin
        nxt_relay = '0;
        nxt_st    = RSS_ST_IDLE;
      end
    endcase
    // abort wins over everything and opens all relays
    if (cfg.abort_p) begin
      nxt_relay = '0;
      nxt_st    = RSS_ST_IDLE;
    end
  end

  // sequencer registers
  // busy follows the next state so status rises with the first close request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff    <= RSS_ST_IDLE;
      idx_ff   <= '0;
      pass_ff  <= 16'h0000;
      dly_ff   <= 16'h0000;
      relay_ff <= '0;
      busy_ff  <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      idx_ff   <= nxt_idx;
      pass_ff  <= nxt_pass;
      dly_ff   <= nxt_dly;
      relay_ff <= nxt_relay;
      busy_ff  <= (nxt_st != RSS_ST_IDLE);
    end
  end

  assign relay_close_o = relay_ff;
  assign scan_busy_o   = busy_ff;
  assign cfg.busy      = busy_ff;
  assign cfg.idx       = idx_ff;
  assign cfg.pass      = pass_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // never two relays closed together
  property p_one_closed;
    $onehot0(relay_ff);
  endproperty
  a_one_closed: assert property (p_one_closed) else $error("two relays closed");

  // a relay only closes out of the all-open state
  property p_break_first;
    (relay_ff != '0) && (relay_ff != $past(relay_ff)) |-> ($past(relay_ff) == '0);
  endproperty
  a_break_first: assert property (p_break_first) else $error("close before open");

  // a count write of zero leaves the count alone
  property p_count_kept;
    u_regs.wr_cnt && (u_regs.wval == 32'h0000_0000) |=> $stable(cfg.count);
  endproperty
  a_count_kept: assert property (p_count_kept) else $error("zero count taken");

  // an oversize delay write leaves the delay alone
  property p_delay_kept;
    u_regs.wr_dly && (u_regs.wval[31:16] != 16'h0000) |=> $stable(cfg.delay);
  endproperty
  a_delay_kept: assert property (p_delay_kept) else $error("bad delay taken");

  // pass number never reaches the count while scanning
  property p_pass_bound;
    busy_ff |-> (pass_ff < cfg.count);
  endproperty
  a_pass_bound: assert property (p_pass_bound) else $error("too many passes");

  // final open of the final pass ends the scan with all open
  property p_end_idle;
    (st_ff == RSS_ST_OPEN) && at_end && last_pass && !cfg.abort_p
      |=> (st_ff == RSS_ST_IDLE) ##1 (!busy_ff && relay_ff == '0);
  endproperty
  a_end_idle: assert property (p_end_idle) else $error("scan did not end");

  // leaving the delay needs the count spent or a step command
  property p_delay_wait;
    (st_ff == RSS_ST_DELAY) && !cfg.imm_p && !dly_done && !cfg.abort_p
      |=> (st_ff == RSS_ST_DELAY);
  endproperty
  a_delay_wait: assert property (p_delay_wait) else $error("delay cut short");

  // immediate source never lingers in armed
  property p_imm_src;
    (st_ff == RSS_ST_ARMED) && (cfg.src_mode == RSS_SRC_IMM) |=> (st_ff != RSS_ST_ARMED);
  endproperty
  a_imm_src: assert property (p_imm_src) else $error("immediate source waited");

  // selected line rise moves armed on
  property p_line_step;
    (st_ff == RSS_ST_ARMED) && (cfg.src_mode == RSS_SRC_TTL) && trig_evt && !cfg.abort_p
      |=> (st_ff == RSS_ST_DELAY) || (st_ff == RSS_ST_OPEN);
  endproperty
  a_line_step: assert property (p_line_step) else $error("line event ignored");

  // step command opens at once from armed or delay
  property p_imm_cmd;
    ((st_ff == RSS_ST_ARMED) || (st_ff == RSS_ST_DELAY)) && cfg.imm_p && !cfg.abort_p
      |=> (st_ff == RSS_ST_OPEN) ##1 (relay_ff == '0);
  endproperty
  a_imm_cmd: assert property (p_imm_cmd) else $error("step command late");

  // a closed relay means a scan is running
  property p_idle_open;
    !busy_ff |-> (relay_ff == '0);
  endproperty
  a_idle_open: assert property (p_idle_open) else $error("relay closed while idle");

  // initiate closes the first relay of the list two cycles on
  property p_first_close;
    (st_ff == RSS_ST_IDLE) && cfg.init_p && !cfg.abort_p
      |=> (st_ff == RSS_ST_CLOSE) ##1 (relay_ff == N'(1));
  endproperty
  a_first_close: assert property (p_first_close) else $error("scan start wrong");

  // with a line selected, armed waits for that line's event
  property p_line_quiet;
    (st_ff == RSS_ST_ARMED) && (cfg.src_mode == RSS_SRC_TTL) && !trig_evt && !cfg.imm_p &&
      !cfg.abort_p |=> (st_ff == RSS_ST_ARMED);
  endproperty
  a_line_quiet: assert property (p_line_quiet) else $error("stepped without event");

  // hold source moves only on the step command
  property p_hold_src;
    (st_ff == RSS_ST_ARMED) && (cfg.src_mode == RSS_SRC_HOLD) && !cfg.imm_p && !cfg.abort_p
      |=> (st_ff == RSS_ST_ARMED);
  endproperty
  a_hold_src: assert property (p_hold_src) else $error("hold source stepped");

  c_scan_done: cover property ((st_ff == RSS_ST_OPEN) && at_end && last_pass);
  c_delay_run: cover property ((st_ff == RSS_ST_DELAY) && dly_done);
  c_wrap_pass: cover property ((st_ff == RSS_ST_OPEN) && at_end && !last_pass);
  c_imm_step:  cover property ((st_ff == RSS_ST_DELAY) && cfg.imm_p);
  c_line_evt:  cover property ((st_ff == RSS_ST_ARMED) && (cfg.src_mode == RSS_SRC_TTL) && trig_evt);
endmodule : rss_top

// >>> sim/rss_trig_model.sv
// backplane trigger source: raises one selected line for a chosen number of cycles
module rss_trig_model (
  // clock
  input  wire logic       clk_sys,
  // request from the bench: fire for one cycle, line number, high time
  input  wire logic       fire,
  input  wire logic [2:0] line,
  input  wire logic [2:0] len,
  // backplane lines, active high, driven low when idle
  output logic [7:0]      trig_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_ff;  // cycles left with the line high
  logic [2:0] sel_ff;   // line being raised
  initial hold_ff = 3'h0;
  initial sel_ff = 3'h0;
  // a short len models a prompt source, a long one a slow source;
  // the bench spaces fires so the line is low for several cycles between events
  always @(posedge clk_sys) begin
    if (fire) begin
      hold_ff <= len;
      sel_ff  <= line;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
  end
  // only the selected line moves, the other seven stay low
  assign trig_line_o = (hold_ff != 3'h0) ? (8'h01 << sel_ff) : 8'h00;
endmodule : rss_trig_model

// >>> sim/rss_top_tb.sv
// bench for the scan sequencer: register tasks plus scan scenarios
module rss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rss_pkg::*;
  localparam int NR = 8;  // relays in the instance
  localparam int TK = 4;  // cycles per delay unit, shortened
  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  logic          cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]    adr = 8'h00;
  logic [3:0]    sel = 4'hF;   // full words only
  logic [31:0]   wdat = 32'h0;
  logic [31:0]   rdat;
  logic          ack, busy;
  logic [7:0]    trig;
  logic [NR-1:0] relay, prev_ff = '0;
  logic          fire = 1'b0;
  logic [2:0]    fline = 3'h0, flen = 3'h4;
  int            n_errors = 0, n_compared = 0, dt, log_q[$];
  always #2.5 clk_sys = ~clk_sys;
  rss_top #(.N(NR), .TICK_CYCLES(TK)) u_rss_top (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .trig_line_i(trig), .relay_close_o(relay), .scan_busy_o(busy));
  rss_trig_model u_rss_trig_model (
    .clk_sys(clk_sys), .fire(fire), .line(fline), .len(flen), .trig_line_o(trig));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rel(input logic [NR-1:0] got, input logic [NR-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t relays %b expected %b", $time, got, exp);
    end
  endtask : chk_rel
  task automatic chk_rng(input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("[ERR] %0t wait %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask : chk_rng
  // one classic cycle: hold everything until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 100);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 100) begin
      n_errors++;
      $display("[ERR] %0t bus answer missing", $time);
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk
  // program a scan and initiate it, returning once busy is up
  task automatic start(input logic [31:0] src, input logic [31:0] dly,
                       input logic [31:0] cnt, input logic [31:0] len);
    int k;
    wr(RSS_OFF_SRC, src); wr(RSS_OFF_DELAY, dly);
    wr(RSS_OFF_COUNT, cnt); wr(RSS_OFF_LEN, len);
    log_q.delete();
    wr(RSS_OFF_CTRL, 32'h1);
    k = 0;
    while (busy !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    chk({31'h0, busy}, 32'h1);
  endtask : start
  task automatic wait_change(output int d);
    logic [NR-1:0] v;
    v = relay;
    d = 0;
    do begin
      @(posedge clk_sys);
      d++;
    end while (relay === v && d < 1000);
  endtask : wait_change
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    chk({31'h0, busy}, 32'h0);
    chk_rel(relay, '0);
  endtask : wait_idle
  task automatic pulse(input logic [2:0] ln);
    @(posedge clk_sys);
    fline <= ln; fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask : pulse
  // closure log, plus at most one closed relay and an open step between two closures
  always @(posedge clk_sys) begin
    if (!rst && relay !== prev_ff && relay !== '0) begin
      chk({31'h0, prev_ff !== '0}, 32'h0);
      for (int i = 0; i < NR; i++) if (relay[i]) log_q.push_back(i);
    end
    if (!rst) chk({31'h0, (relay & (relay - 1'b1)) !== '0}, 32'h0);
    prev_ff <= relay;
  end
  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // watchdog: the tests need a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values and an unmapped place
    rd_chk(RSS_OFF_COUNT, 32'h1);
    rd_chk(RSS_OFF_DELAY, 32'h0);
    rd_chk(RSS_OFF_SRC, 32'h0);
    rd_chk(RSS_OFF_LEN, NR);
    rd_chk(RSS_OFF_STAT, 32'h0);
    rd_chk(8'h1C, 32'h0);
    // out-of-range values are refused, boundaries are kept
    wr(RSS_OFF_COUNT, 32'h0); rd_chk(RSS_OFF_COUNT, 32'h1);
    wr(RSS_OFF_COUNT, 32'h10000); rd_chk(RSS_OFF_COUNT, 32'h1);
    rd_chk(RSS_OFF_STAT, 32'h2);
    wr(RSS_OFF_COUNT, 32'hFFFF); rd_chk(RSS_OFF_COUNT, 32'hFFFF);
    wr(RSS_OFF_DELAY, 32'h10000); rd_chk(RSS_OFF_DELAY, 32'h0);
    wr(RSS_OFF_DELAY, 32'hFFFF); rd_chk(RSS_OFF_DELAY, 32'hFFFF);
    wr(RSS_OFF_SRC, 32'h3); rd_chk(RSS_OFF_SRC, 32'h0);
    rd_chk(RSS_OFF_STAT, 32'hE);
    wr(RSS_OFF_STAT, 32'hE); rd_chk(RSS_OFF_STAT, 32'h0);
    wr(RSS_OFF_LEN, 32'h0); wr(RSS_OFF_LEN, NR + 1); rd_chk(RSS_OFF_LEN, NR);
    // immediate source, no delay, three relays twice
    start(32'h0, 32'h0, 32'h2, 32'h3);
    wait_idle();
    chk(log_q.size(), 32'h6);
    foreach (log_q[i]) chk(log_q[i], i % 3);
    // immediate source still waits the delay before opening
    start(32'h0, 32'h2, 32'h1, 32'h2);
    if (relay === '0) wait_change(dt);
    wait_change(dt);
    chk_rng(dt, 2 * TK, 2 * TK + 12);
    wait_idle();
    // backplane line 2, wrong line ignored, then delay after each edge
    start(32'h21, 32'h0, 32'h2, 32'h2);
    repeat (20) @(posedge clk_sys);
    chk_rel(relay, 8'h01);
    pulse(3'h3);
    repeat (20) @(posedge clk_sys);
    chk_rel(relay, 8'h01);
    pulse(3'h2);
    wait_change(dt);
    chk_rng(dt, 1, 20);
    wait_change(dt);
    chk_rel(relay, 8'h02);
    wr(RSS_OFF_DELAY, 32'h3);
    flen <= 3'h7;
    pulse(3'h2);
    wait_change(dt);
    chk_rng(dt, 3 * TK, 3 * TK + 20);
    wait_change(dt);
    rd_chk(RSS_OFF_POS, 32'h0001_0000);
    pulse(3'h2);
    wait_change(dt);
    wait_change(dt);
    pulse(3'h2);
    wait_idle();
    chk(log_q.size(), 32'h4);
    foreach (log_q[i]) chk(log_q[i], i % 2);
    // hold source: only the step command moves, without the long delay
    start(32'h2, 32'h64, 32'h2, 32'h3);
    repeat (20) @(posedge clk_sys);
    chk_rel(relay, 8'h01);
    wr(RSS_OFF_CTRL, 32'h4);
    wait_change(dt);
    chk_rng(dt, 0, 6);
    wait_change(dt);
    chk_rel(relay, 8'h02);
    rd_chk(RSS_OFF_POS, 32'h1);
    // immediate source now waits the long delay; the step command cuts it short
    wr(RSS_OFF_SRC, 32'h0);
    rd_chk(RSS_OFF_STAT, 32'h1);
    wr(RSS_OFF_CTRL, 32'h4);
    wait_change(dt);
    chk_rng(dt, 0, 6);
    wait_change(dt);
    chk_rel(relay, 8'h04);
    wr(RSS_OFF_CTRL, 32'h2);
    wait_idle();
    // reset after the aborted scan brings the defaults back
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(RSS_OFF_COUNT, 32'h1);
    rd_chk(RSS_OFF_DELAY, 32'h0);
    rd_chk(RSS_OFF_LEN, NR);
    close_out();
  end
endmodule : rss_top_tb
